// ### rtl/plcr_cfg.svh
//==========================================================================
//==========================================================================
`ifndef PLCR_CFG_SVH
`define PLCR_CFG_SVH

//==========================================================================
// Register offsets
`define PLCR_OFF_LINK_CONTROL 12'h050
`define PLCR_OFF_IRQ_STATUS 12'h100
`define PLCR_OFF_IRQ_CLEAR 12'h104
`define PLCR_OFF_IRQ_ENABLE 12'h108

//==========================================================================
// Link control field positions
`define PLCR_BIT_ASPM_LO 0
`define PLCR_BIT_ASPM_HI 1
`define PLCR_BIT_RCB 3
`define PLCR_BIT_LINK_DISABLE 4
`define PLCR_BIT_RETRAIN 5
`define PLCR_BIT_COMMON_CLOCK_CONFIG 6
`define PLCR_BIT_EXTENDED_SYNC 7
`define PLCR_BIT_CLKPM 8
`define PLCR_BIT_AWDIS 9
`define PLCR_BIT_BWIE 10
`define PLCR_BIT_ABWIE 11

//==========================================================================
// Interrupt register bit positions
`define PLCR_IRQ_BW_MGMT 0
`define PLCR_IRQ_AUTO_BW 1

//==========================================================================
// Reset values and encodings
`define PLCR_ASPM_DISABLED 2'h0
`define PLCR_ASPM_L0S 2'h1
`define PLCR_ASPM_L1 2'h2
`define PLCR_ASPM_BOTH 2'h3
`define PLCR_IRQ_EN_RESET 2'h3

`endif

// ### rtl/plcr_pkg.sv
//==========================================================================
// Types shared by the link control block
package plcr_pkg;

  typedef enum logic [1:0] {
    PLCR_ASPM_OFF,
    PLCR_ASPM_L0S_ONLY,
    PLCR_ASPM_L1_ONLY,
    PLCR_ASPM_L0S_L1
  } plcr_aspm_t;

  // Whole block state, registered in one process
  typedef struct packed {
    logic [1:0] aspm;
    logic linkDisable;
    logic commonClock;
    logic extendedSync;
    logic autoWidthDisable;
    logic bwMgmtIrqEn;
    logic autoBwIrqEn;
    logic retrainPulse;
    logic retrainPending;
    logic [1:0] irqStatus;
    logic [1:0] irqEnable;
    logic [15:0] readData;
    logic irq;
  } plcr_state_t;

endpackage : plcr_pkg

// ### rtl/plcr_link_control.sv
`timescale 1ns/1ps
`include "plcr_cfg.svh"

module plcr_link_control
  import plcr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Port configuration, same clock
  input wire logic portIsUpstream,
  input wire logic registerUnlock,
  input wire logic legacyMode11,
  input wire logic bwNotificationCapable,
  // Serial EEPROM configuration load
  input wire logic eepromLoadValid,
  input wire logic [1:0] eepromAspm,
  // Physical layer events
  input wire logic retrainDone,
  input wire logic linkDownEvent,
  input wire logic reliabilityChange,
  input wire logic autonomousBwChange,
  // Controls to link and physical layers
  output logic aspmL0sEnable,
  output logic aspmL1Enable,
  output logic linkDisable,
  output logic retrainRecovery,
  output logic commonClockConfig,
  output logic extendedSync,
  output logic autoWidthDisable,
  output logic bwMgmtIrqEnable,
  output logic autoBwIrqEnable,
  // Interrupt
  output logic irq
);

  //==========================================================================
  // Elaboration checks
  // The highest offset, the interrupt enable register, needs nine address bits.
  // A narrower bus would alias the interrupt registers onto offsets 0x000 to 0x008,
  // so the build is refused rather than left to decode the wrong register.
  if (ADDR_W < 9) begin : g_addr_check
    $error("ADDR_W too small to reach the register offsets");
  end

  //==========================================================================
  // Qualifiers
  plcr_state_t state_r;
  plcr_state_t state_nxt;
  logic upstreamLocked;
  logic gen2Fields;
  logic bwEnAllowed;
  logic [15:0] ctlView;
  logic wrCtl;
  logic wrClr;
  logic wrEn;
  logic retrainWrite;
  logic [1:0] bwEvent;

  // Upstream controls stay inert until switch control unlocks them.
  // Configuration inputs are on this clock, so no synchroniser is needed.
  assign upstreamLocked = portIsUpstream & ~registerUnlock;
  assign gen2Fields = ~legacyMode11;
  assign bwEnAllowed = bwNotificationCapable & gen2Fields;

  assign wrCtl = regWr & (regAddr == ADDR_W'(`PLCR_OFF_LINK_CONTROL));
  assign wrClr = regWr & (regAddr == ADDR_W'(`PLCR_OFF_IRQ_CLEAR));
  assign wrEn = regWr & (regAddr == ADDR_W'(`PLCR_OFF_IRQ_ENABLE));
  assign retrainWrite = wrCtl & regWdata[`PLCR_BIT_RETRAIN] & ~upstreamLocked;

  // Software view of the link control register
  always_comb begin
    ctlView = 16'h0000;
    ctlView[`PLCR_BIT_ASPM_HI:`PLCR_BIT_ASPM_LO] = state_r.aspm;
    ctlView[`PLCR_BIT_LINK_DISABLE] = state_r.linkDisable & ~upstreamLocked;
    ctlView[`PLCR_BIT_COMMON_CLOCK_CONFIG] = state_r.commonClock;
    ctlView[`PLCR_BIT_EXTENDED_SYNC] = state_r.extendedSync;
    ctlView[`PLCR_BIT_AWDIS] = state_r.autoWidthDisable & gen2Fields;
    ctlView[`PLCR_BIT_BWIE] = state_r.bwMgmtIrqEn & bwEnAllowed;
    ctlView[`PLCR_BIT_ABWIE] = state_r.autoBwIrqEn & bwEnAllowed;
  end

  // Bandwidth events only count when the link did not go down meanwhile.
  // A retrain completion is only ours if software asked for the retraining.
  always_comb begin
    bwEvent = 2'h0;
    bwEvent[`PLCR_IRQ_BW_MGMT] = bwEnAllowed & ~linkDownEvent &
      ((state_r.retrainPending & retrainDone) | reliabilityChange);
    bwEvent[`PLCR_IRQ_AUTO_BW] = bwEnAllowed & ~linkDownEvent & autonomousBwChange;
  end

  //==========================================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.retrainPulse = 1'b0;
    // Configuration load replaces the reset encoding
    if (eepromLoadValid) begin
      state_nxt.aspm = eepromAspm;
    end
    // All fields of a retraining write land with the pulse
    if (wrCtl) begin
      state_nxt.aspm = regWdata[`PLCR_BIT_ASPM_HI:`PLCR_BIT_ASPM_LO];
      if (!upstreamLocked) begin
        state_nxt.linkDisable = regWdata[`PLCR_BIT_LINK_DISABLE];
      end
      state_nxt.commonClock = regWdata[`PLCR_BIT_COMMON_CLOCK_CONFIG];
      state_nxt.extendedSync = regWdata[`PLCR_BIT_EXTENDED_SYNC];
      if (gen2Fields) begin
        state_nxt.autoWidthDisable = regWdata[`PLCR_BIT_AWDIS];
      end
      if (bwEnAllowed) begin
        state_nxt.bwMgmtIrqEn = regWdata[`PLCR_BIT_BWIE];
        state_nxt.autoBwIrqEn = regWdata[`PLCR_BIT_ABWIE];
      end
    end
    state_nxt.retrainPulse = retrainWrite;
    // Track a software retraining until it finishes or the link drops
    if (retrainWrite) begin
      state_nxt.retrainPending = 1'b1;
    end else if (retrainDone || linkDownEvent) begin
      state_nxt.retrainPending = 1'b0;
    end
    if (wrEn) begin
      state_nxt.irqEnable = regWdata[1:0];
    end
    // Clear first, then set, so a same-cycle event is kept.
    // Losing an event to a racing clear would hide a real bandwidth change.
    if (wrClr) begin
      state_nxt.irqStatus = state_r.irqStatus & ~regWdata[1:0];
    end
    state_nxt.irqStatus = state_nxt.irqStatus | bwEvent;
    // Read data stand only in the cycle after the strobe
    state_nxt.readData = 16'h0000;
    if (regRd) begin
      if (regAddr == ADDR_W'(`PLCR_OFF_LINK_CONTROL)) begin
        state_nxt.readData = ctlView;
      end else if (regAddr == ADDR_W'(`PLCR_OFF_IRQ_STATUS)) begin
        state_nxt.readData = {14'h0000, state_r.irqStatus};
      end else if (regAddr == ADDR_W'(`PLCR_OFF_IRQ_ENABLE)) begin
        state_nxt.readData = {14'h0000, state_r.irqEnable};
      end
    end
    // Level interrupt from next status so it tracks the sticky bits exactly
    state_nxt.irq = (state_nxt.irqStatus[`PLCR_IRQ_BW_MGMT] & state_nxt.irqEnable[`PLCR_IRQ_BW_MGMT] &
                     state_nxt.bwMgmtIrqEn & bwEnAllowed) |
                    (state_nxt.irqStatus[`PLCR_IRQ_AUTO_BW] & state_nxt.irqEnable[`PLCR_IRQ_AUTO_BW] &
                     state_nxt.autoBwIrqEn & bwEnAllowed);
  end

  //==========================================================================
  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= '0;
      state_r.aspm <= `PLCR_ASPM_DISABLED;
      state_r.irqEnable <= `PLCR_IRQ_EN_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  //==========================================================================
  // Outputs straight from flops
  assign regRdata = state_r.readData;
  assign aspmL0sEnable = state_r.aspm[`PLCR_BIT_ASPM_LO];
  assign aspmL1Enable = state_r.aspm[`PLCR_BIT_ASPM_HI];
  assign linkDisable = state_r.linkDisable;
  assign retrainRecovery = state_r.retrainPulse;
  assign commonClockConfig = state_r.commonClock;
  assign extendedSync = state_r.extendedSync;
  assign autoWidthDisable = state_r.autoWidthDisable;
  assign bwMgmtIrqEnable = state_r.bwMgmtIrqEn;
  assign autoBwIrqEnable = state_r.autoBwIrqEn;
  assign irq = state_r.irq;

  //==========================================================================
  // Checks
  // All checks share the one clock; reset abandons any attempt in flight.
  // Checks on written fields look one cycle after the write strobe,
  // since every control output is registered.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);


  chk_aspm_write: assert property (wrCtl && !eepromLoadValid |=>
    state_r.aspm == $past(regWdata[1:0]))
    else $error("aspm field did not take written value");

  chk_eeprom_load: assert property (eepromLoadValid && !wrCtl |=>
    state_r.aspm == $past(eepromAspm))
    else $error("eeprom load did not reach aspm field");

  chk_rcb_zero: assert property (regRd && regAddr == ADDR_W'(`PLCR_OFF_LINK_CONTROL) |=>
    regRdata[`PLCR_BIT_RCB] == 1'b0 && regRdata[15:12] == 4'h0 && regRdata[2] == 1'b0)
    else $error("hardwired zero bits read nonzero");

  chk_link_disable_hold: assert property (linkDisable && !wrCtl |=> linkDisable)
    else $error("link disable dropped without a write");

  chk_link_disable_locked: assert property (wrCtl && upstreamLocked && !linkDisable |=> !linkDisable)
    else $error("locked upstream link was disabled");

  // Back-to-back retraining writes may legally keep the pulse high
  chk_retrain_pulse: assert property (wrCtl && regWdata[5] && !upstreamLocked |=>
    retrainRecovery ##1 (!retrainRecovery || $past(retrainWrite)))
    else $error("retrain write gave no single pulse");

  chk_retrain_locked: assert property (wrCtl && upstreamLocked |=> !retrainRecovery)
    else $error("locked upstream retrain took effect");

  chk_retrain_reads: assert property (regRd |=> regRdata[`PLCR_BIT_RETRAIN] == 1'b0 &&
    regRdata[`PLCR_BIT_CLKPM] == 1'b0)
    else $error("retrain or clock pm bit read nonzero");

  chk_retrain_fields: assert property (retrainRecovery |->
    commonClockConfig == $past(regWdata[6]) && extendedSync == $past(regWdata[7]))
    else $error("retrain pulse without its write fields");

  chk_legacy_zero: assert property (legacyMode11 && regRd && regAddr == ADDR_W'(`PLCR_OFF_LINK_CONTROL)
    |=> regRdata[11:9] == 3'h0)
    else $error("1.1 mode bits read nonzero");

  chk_lbn_zero: assert property (!bwNotificationCapable |=> !irq)
    else $error("interrupt without notification capability");

  chk_bw_status: assert property (state_r.retrainPending && retrainDone && !linkDownEvent &&
    bwEnAllowed |=> state_r.irqStatus[0])
    else $error("retrain completion did not set status");

  chk_irq_raise: assert property (bwEvent[0] && state_r.irqEnable[0] && state_r.bwMgmtIrqEn &&
    !wrCtl && !wrEn |=> irq)
    else $error("bandwidth event raised no interrupt");

  // Power management encodings reach both entry enables
  chk_aspm_both: assert property (wrCtl && !eepromLoadValid && regWdata[1:0] == `PLCR_ASPM_BOTH |=>
    aspmL0sEnable && aspmL1Enable)
    else $error("both entries not enabled");

  chk_aspm_off: assert property (wrCtl && !eepromLoadValid && regWdata[1:0] == `PLCR_ASPM_DISABLED |=>
    !aspmL0sEnable && !aspmL1Enable)
    else $error("low power entry left enabled");

  // A register write beats a configuration load in the same cycle
  chk_write_wins: assert property (wrCtl && eepromLoadValid |=>
    state_r.aspm == $past(regWdata[1:0]))
    else $error("eeprom load overrode a register write");

  // Link disable follows writes unless the upstream port is locked
  chk_link_disable_write: assert property (wrCtl && !upstreamLocked |=>
    linkDisable == $past(regWdata[4]))
    else $error("link disable did not take written value");

  chk_link_disable_view: assert property (regRd && regAddr == ADDR_W'(`PLCR_OFF_LINK_CONTROL) &&
    upstreamLocked |=> !regRdata[`PLCR_BIT_LINK_DISABLE])
    else $error("locked link disable read nonzero");

  // Plain read-write link flags; width disable holds its value in 1.1 mode
  chk_common_clock_config_write: assert property (wrCtl |=> commonClockConfig == $past(regWdata[6]))
    else $error("common clock did not take written value");

  chk_extended_sync_write: assert property (wrCtl |=> extendedSync == $past(regWdata[7]))
    else $error("extended sync did not take written value");

  chk_awd_write: assert property (wrCtl && gen2Fields |=>
    autoWidthDisable == $past(regWdata[9]))
    else $error("width disable did not take written value");

  chk_awd_legacy: assert property (wrCtl && legacyMode11 |=> $stable(autoWidthDisable))
    else $error("1.1 mode write changed width disable");

  // Interrupt enables are writable only with notification capability
  chk_bwie_write: assert property (wrCtl && bwEnAllowed |=>
    bwMgmtIrqEnable == $past(regWdata[10]))
    else $error("bandwidth irq enable did not take written value");

  chk_abwie_write: assert property (wrCtl && bwEnAllowed |=>
    autoBwIrqEnable == $past(regWdata[11]))
    else $error("autonomous irq enable did not take written value");

  chk_bw_gated: assert property (wrCtl && !bwEnAllowed |=>
    $stable(bwMgmtIrqEnable) && $stable(autoBwIrqEnable))
    else $error("irq enables changed without capability");

  chk_bw_view: assert property (regRd && regAddr == ADDR_W'(`PLCR_OFF_LINK_CONTROL) &&
    !bwEnAllowed |=> regRdata[11:10] == 2'h0)
    else $error("irq enables read nonzero without capability");

  // Interrupt line follows enabled sticky status
  chk_abw_irq: assert property (bwEvent[1] && state_r.irqEnable[1] && state_r.autoBwIrqEn &&
    !wrCtl && !wrEn |=> irq)
    else $error("autonomous event raised no interrupt");

  chk_irq_cause: assert property (irq |-> (state_r.irqStatus & state_r.irqEnable) != 2'h0)
    else $error("interrupt without enabled status");

  // Status bits are sticky and an event beats a same-cycle clear
  chk_status_sticky: assert property (state_r.irqStatus[0] && !wrClr |=> state_r.irqStatus[0])
    else $error("status dropped without a clear");

  chk_set_beats_clear: assert property (bwEvent[0] && wrClr |=> state_r.irqStatus[0])
    else $error("clear swallowed a same-cycle event");

  chk_linkdown_block: assert property (linkDownEvent && !state_r.irqStatus[0] |=>
    !state_r.irqStatus[0])
    else $error("status set across link down");

  chk_pending_clear: assert property (linkDownEvent && !retrainWrite |=>
    !state_r.retrainPending)
    else $error("pending retrain survived link down");

endmodule : plcr_link_control

// ### tb/plcr_link_control_tb.sv
`timescale 1ns/1ps
`include "plcr_cfg.svh"

module plcr_link_control_tb;
  import plcr_pkg::*;
  //==========================================================================
  // Stimulus and observed signals
  logic clk_sys = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [15:0] regWdata = 16'h0000, rd;
  wire logic [15:0] regRdata;
  logic up = 1'b0, unl = 1'b0, leg = 1'b0, cap = 1'b1, eeV = 1'b0;
  logic [1:0] eeA = 2'h0;
  logic rDone = 1'b0, lDown = 1'b0, relCh = 1'b0, abwCh = 1'b0;
  wire logic l0s, l1, link_disable, ret, common_clock_config, extended_sync, awd, bwie, abwie, irq;
  int nFail = 0, totalChecks = 0;
  typedef struct {logic u, k, g, c; logic [15:0] wd, rd; logic ld, rt;} plcr_row_t;
  plcr_row_t rows [8] = '{
    '{0, 0, 0, 1, 16'hFFFF, 16'h0ED3, 1, 1}, '{0, 0, 0, 1, 16'h0001, 16'h0001, 0, 0},
    '{0, 0, 0, 1, 16'h0002, 16'h0002, 0, 0}, '{0, 0, 0, 1, 16'h0000, 16'h0000, 0, 0},
    '{1, 0, 0, 1, 16'hFFFF, 16'h0EC3, 0, 0}, '{1, 1, 0, 1, 16'h0030, 16'h0010, 1, 1},
    '{0, 0, 1, 1, 16'h0FFF, 16'h00D3, 1, 1}, '{0, 0, 0, 0, 16'h0E00, 16'h0200, 0, 0}};

  always #5 clk_sys = ~clk_sys;

  plcr_link_control u_dut (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .portIsUpstream(up), .registerUnlock(unl),
    .legacyMode11(leg), .bwNotificationCapable(cap), .eepromLoadValid(eeV), .eepromAspm(eeA),
    .retrainDone(rDone), .linkDownEvent(lDown), .reliabilityChange(relCh), .autonomousBwChange(abwCh),
    .aspmL0sEnable(l0s), .aspmL1Enable(l1), .linkDisable(link_disable), .retrainRecovery(ret),
    .commonClockConfig(common_clock_config), .extendedSync(extended_sync), .autoWidthDisable(awd), .bwMgmtIrqEnable(bwie),
    .autoBwIrqEnable(abwie), .irq(irq));

  //==========================================================================
  // Compare, bus and event tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Write taken at the second edge; pulse outputs are sampled just after it
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdReg(input logic [11:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask : rdReg

  // One-cycle physical layer event; 0 retrain done, 1 reliability, 2 autonomous
  task automatic ev(input int which, input logic down);
    @(posedge clk_sys);
    rDone <= (which == 0);
    relCh <= (which == 1);
    abwCh <= (which == 2);
    lDown <= down;
    @(posedge clk_sys);
    {rDone, relCh, abwCh, lDown} <= 4'h0;
    #1;
  endtask : ev

  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : reportAndStop

  //==========================================================================
  // Watchdog, far beyond the ninety or so cycles the tests need
  initial begin
    #200000;
    nFail++;
    reportAndStop();
  end

  //==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rdReg(`PLCR_OFF_LINK_CONTROL);
    chk("ctl reset", 16'h0000, rd);
    rdReg(`PLCR_OFF_IRQ_ENABLE);
    chk("irq enable reset", 16'h0003, rd);
    $display("reset test done");
    // Row table: config, write, pulse and outputs, then readback
    foreach (rows[i]) begin
      @(posedge clk_sys);
      {up, unl, leg, cap} <= {rows[i].u, rows[i].k, rows[i].g, rows[i].c};
      wr(`PLCR_OFF_LINK_CONTROL, rows[i].wd);
      chk("retrain pulse", {15'h0, rows[i].rt}, {15'h0, ret});
      // Retraining sees the new fields in the pulse cycle itself
      chk("ctl outputs", {8'h0, rows[i].rd[11:9], rows[i].rd[7:6], rows[i].ld, rows[i].rd[1:0]},
        {8'h0, abwie, bwie, awd, extended_sync, common_clock_config, link_disable, l1, l0s});
      rdReg(`PLCR_OFF_LINK_CONTROL);
      chk("ctl readback", rows[i].rd, rd);
      chk("retrain single", 16'h0000, {15'h0, ret});
      $display("row %0d done", i);
    end
    // Serial EEPROM load replaces the power management field
    @(posedge clk_sys);
    {up, unl, leg, cap, eeV, eeA} <= {4'h1, 1'b1, 2'h2};
    @(posedge clk_sys);
    eeV <= 1'b0;
    rdReg(`PLCR_OFF_LINK_CONTROL);
    chk("eeprom aspm", 16'h0202, rd);
    chk("eeprom l1", 16'h0001, {15'h0, l1});
    // Unmapped and write-only places read zero
    rdReg(12'h0FF);
    chk("unmapped read", 16'h0000, rd);
    rdReg(`PLCR_OFF_IRQ_CLEAR);
    chk("clear read", 16'h0000, rd);
    $display("eeprom and map test done");
    // Interrupts: set, clear, mask, link-down suppression
    {up, unl} <= 2'b00;
    wr(`PLCR_OFF_LINK_CONTROL, 16'h0C20);
    ev(0, 1'b0);
    chk("bw status irq", 16'h0001, {15'h0, irq});
    rdReg(`PLCR_OFF_IRQ_STATUS);
    chk("bw status", 16'h0001, rd);
    wr(`PLCR_OFF_IRQ_CLEAR, 16'h0001);
    chk("irq after clear", 16'h0000, {15'h0, irq});
    ev(2, 1'b0);
    chk("auto bw irq", 16'h0001, {15'h0, irq});
    wr(`PLCR_OFF_IRQ_ENABLE, 16'h0000);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(`PLCR_OFF_IRQ_ENABLE, 16'h0003);
    wr(`PLCR_OFF_LINK_CONTROL, 16'h0000);
    chk("ctl enables off", 16'h0000, {15'h0, irq});
    wr(`PLCR_OFF_IRQ_CLEAR, 16'h0003);
    wr(`PLCR_OFF_LINK_CONTROL, 16'h0420);
    ev(0, 1'b1);
    rdReg(`PLCR_OFF_IRQ_STATUS);
    chk("link down no status", 16'h0000, rd);
    ev(1, 1'b0);
    rdReg(`PLCR_OFF_IRQ_STATUS);
    chk("reliability status", 16'h0001, rd);
    chk("reliability irq", 16'h0001, {15'h0, irq});
    $display("interrupt test done");
    // Mid-run reset returns every field to its reset value
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rdReg(`PLCR_OFF_LINK_CONTROL);
    chk("ctl after reset", 16'h0000, rd);
    chk("irq after reset", 16'h0000, {15'h0, irq});
    $display("mid-run reset test done");
    reportAndStop();
  end
endmodule : plcr_link_control_tb
